//--- common/clh_map.svh
`ifndef CLH_MAP_SVH
`define CLH_MAP_SVH
// ---------------------------------------------------------------
// bus select values
// ---------------------------------------------------------------
`define CLH_SEL_INSTR   1'b0
`define CLH_SEL_DATA    1'b1
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CLH_CLK_NS      10
`define CLH_EXEC_NS     40000
`define CLH_NOM_OSC_KHZ 250
`define CLH_ROW_CYC     1000
`define CLH_MAX_EXEC    4095
// ---------------------------------------------------------------
// instruction field positions
// ---------------------------------------------------------------
`define CLH_FS_WIDTH    4
`define CLH_FS_LINES    3
`define CLH_FS_FONT     2
`define CLH_EM_DIR      1
`define CLH_EM_SHIFT    0
`define CLH_DC_DISP     2
`define CLH_DC_CURS     1
`define CLH_DC_BLINK    0
`define CLH_SH_DISP     3
`define CLH_SH_RIGHT    2
`define CLH_BUSY_BIT    7
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define CLH_RST_WIDE    1'b1
`define CLH_RST_LINES   1'b0
`define CLH_RST_FONT    1'b0
`define CLH_RST_DIR     1'b1
// ---------------------------------------------------------------
// display geometry
// ---------------------------------------------------------------
`define CLH_COM_1L_SMALL 5'h08
`define CLH_COM_1L_TALL  5'h0b
`define CLH_COM_2L       5'h10
`define CLH_DRV_1L       4'h9
`define CLH_DRV_2L       4'h4
`define CLH_CHARS_1L     7'h50
`define CLH_CHARS_2L     7'h28
`define CLH_LINE2_BASE   7'h40
`define CLH_ROWS_LINE    5'h08
`define CLH_GLYPH_COLS   3'h5
`define CLH_CODE_GLYPHS  8'h08
`endif

//--- common/clh_pkg.sv
package clh_pkg;
   typedef logic [7:0] clh_byte_t;
   typedef logic [6:0] clh_addr_t;

   typedef enum logic [3:0] {
      CLH_OP_NONE  = 4'b0000,
      CLH_OP_CLEAR = 4'b0001,
      CLH_OP_HOME  = 4'b0010,
      CLH_OP_ENTRY = 4'b0011,
      CLH_OP_DISP  = 4'b0100,
      CLH_OP_SHIFT = 4'b0101,
      CLH_OP_FUNC  = 4'b0110,
      CLH_OP_GLYPH = 4'b0111,
      CLH_OP_TEXT  = 4'b1000
   } clh_op_t;

   // leading-one position picks the instruction
   function automatic clh_op_t clh_decode(input clh_byte_t b);
      clh_op_t op;
      op = CLH_OP_NONE;
      if (b[7])           op = CLH_OP_TEXT;
      else if (b[6])      op = CLH_OP_GLYPH;
      else if (b[5])      op = CLH_OP_FUNC;
      else if (b[4])      op = CLH_OP_SHIFT;
      else if (b[3])      op = CLH_OP_DISP;
      else if (b[2])      op = CLH_OP_ENTRY;
      else if (b[1])      op = CLH_OP_HOME;
      else if (b[0])      op = CLH_OP_CLEAR;
      return op;
   endfunction
endpackage

//--- test/clh_expansion_model.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------
// expansion driver chain: shift pulses seen per latched row
// ---------------------------------------------------------------
module clh_expansion_model (
   // clock and reset
   input  wire logic clock,
   input  wire logic rst_n,
   // expansion link
   input  wire logic expansion_latch,
   input  wire logic expansion_shift_clock,
   // row length of the last complete row
   output int        row_bits
);
   int   count;
   logic clk_q;
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         count = 0;
         row_bits = 0;
         clk_q = 1'b0;
      end else begin
         if (expansion_latch) begin
            row_bits = count;
            count = 0;
         end
         if (expansion_shift_clock && !clk_q) count = count + 1;
         clk_q = expansion_shift_clock;
      end
   end
endmodule

//--- test/tb.sv
`timescale 1ns/100ps
module tb;
   import clh_pkg::*;
   logic        clock = 1'b0;
   logic        rst_n = 1'b0;
   logic        register_select = 1'b0;
   logic        wr_stb = 1'b0;
   logic        rd_stb = 1'b0;
   clh_byte_t   wr_data = 8'h00;
   clh_byte_t   rd_data;
   logic        busy_flag_bit;
   logic        bus_width_select;
   logic        two_line_mode;
   logic        tall_font;
   logic        display_on;
   logic        cursor_on;
   logic        blink_on;
   logic [4:0]  common_index;
   logic [4:0]  common_count;
   logic [3:0]  max_drivers;
   logic        expansion_latch;
   logic        expansion_shift_clock;
   logic        narrow = 1'b0;
   logic [15:0] v;
   logic [15:0] n;
   int          row_bits;
   int          failures = 0;
   int          comparisons = 0;

   always #5 clock = ~clock;

   clh_instruction_unit #(.OSC_KHZ(2500), .ROW_CYC(1000)) i_dut (
      .clock(clock), .rst_n(rst_n), .register_select(register_select),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .wr_data(wr_data),
      .rd_data(rd_data), .busy_flag_bit(busy_flag_bit),
      .bus_width_select(bus_width_select), .two_line_mode(two_line_mode),
      .tall_font(tall_font), .display_on(display_on),
      .cursor_on(cursor_on), .blink_on(blink_on),
      .common_count(common_count), .max_drivers(max_drivers),
      .common_index(common_index), .expansion_latch(expansion_latch),
      .expansion_shift_clock(expansion_shift_clock),
      .expansion_alt(), .expansion_data());

   clh_expansion_model i_chain (
      .clock(clock), .rst_n(rst_n), .expansion_latch(expansion_latch),
      .expansion_shift_clock(expansion_shift_clock), .row_bits(row_bits));

   // ------------------------------------------------------------
   // bus tasks
   // ------------------------------------------------------------
   task automatic chk(input string nm, input logic [15:0] s, e);
      comparisons++;
      if (s !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic wr(input logic rs, input clh_byte_t d);
      @(posedge clock);
      register_select <= rs;
      wr_data <= d;
      wr_stb <= 1'b1;
      @(posedge clock);
      wr_stb <= 1'b0;
   endtask

   task automatic rd(input logic rs);
      @(posedge clock);
      register_select <= rs;
      rd_stb <= 1'b1;
      @(posedge clock);
      rd_stb <= 1'b0;
      #1 v = 16'(rd_data);
   endtask

   task automatic idle;
      int   i;
      logic b;
      for (i = 0; i < 1000; i++) begin
         rd(1'b0);
         b = v[7];
         if (narrow) rd(1'b0);
         if (b === 1'b0) return;
      end
      failures++;
      print_verdict;
   endtask

   task automatic op(input logic rs, input clh_byte_t d);
      if (narrow) begin
         wr(rs, {d[7:4], 4'h0});
         wr(rs, {d[3:0], 4'h0});
      end else wr(rs, d);
      idle;
   endtask

   task automatic print_verdict;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // ------------------------------------------------------------
   // sequence
   // ------------------------------------------------------------
   initial begin
      repeat (10) @(posedge clock);
      rst_n <= 1'b1;
      #1 chk("width", 16'(bus_width_select), 16'h1);
      chk("commons", 16'(common_count), 16'h8);
      chk("drivers", 16'(max_drivers), 16'h9);
      op(0, 8'h34);
      chk("tall", 16'(tall_font), 16'h1);
      chk("commons", 16'(common_count), 16'hb);
      op(0, 8'h3c);
      chk("tall", 16'(tall_font), 16'h0);
      chk("commons", 16'(common_count), 16'h10);
      chk("drivers", 16'(max_drivers), 16'h4);
      op(0, 8'h0c);
      chk("display", 16'(display_on), 16'h1);
      chk("cursor", 16'(cursor_on), 16'h0);
      op(0, 8'h0b);
      chk("display off", 16'(display_on), 16'h0);
      chk("blink", 16'(blink_on), 16'h1);
      op(0, 8'h30);
      chk("lines", 16'(two_line_mode), 16'h1);
      $display("test mode done");
      wr(0, 8'h85);
      rd(0);
      chk("busy status", v, 16'h80);
      idle;
      rd(0);
      chk("status", v, 16'h05);
      wr(1, 8'ha5);
      #1 n = 0;
      while (busy_flag_bit === 1'b1 && n < 1000) begin
         @(posedge clock);
         #1 n++;
      end
      chk("busy len", n, 16'd400);
      if (n >= 16'd1000) print_verdict;
      idle;
      op(1, 8'h3c);
      op(1, 8'h99);
      rd(0);
      chk("counter", v, 16'h08);
      op(0, 8'h85);
      rd(1);
      chk("read", v, 16'ha5);
      idle;
      rd(1);
      chk("read next", v, 16'h3c);
      idle;
      op(0, 8'h85);
      rd(1);
      idle;
      op(1, 8'h5a);
      rd(1);
      chk("stale", 16'(v !== 16'h0099), 16'h1);
      idle;
      $display("test memory done");
      op(0, 8'h04);
      op(0, 8'h86);
      rd(1);
      chk("dec read", v, 16'h5a);
      idle;
      rd(0);
      chk("dec counter", v, 16'h05);
      op(0, 8'h43);
      op(1, 8'h1f);
      op(0, 8'h43);
      rd(1);
      chk("glyph", v, 16'h1f);
      idle;
      op(0, 8'h06);
      op(0, 8'h84);
      op(0, 8'h14);
      rd(1);
      chk("shift read", v, 16'ha5);
      idle;
      wr(0, 8'h8a);
      wr(1, 8'h77);
      idle;
      rd(0);
      chk("refused", v, 16'h0a);
      chk("row bits", 16'(row_bits), 16'd200);
      chk("com index", 16'(common_index < common_count), 16'h1);
      $display("test access done");
      wr(0, 8'h20);
      narrow = 1'b1;
      idle;
      chk("width", 16'(bus_width_select), 16'h0);
      op(0, 8'h85);
      rd(0);
      chk("status hi", v, 16'h00);
      rd(0);
      chk("status lo", v, 16'h50);
      rd(1);
      chk("data hi", v, 16'ha0);
      rd(1);
      chk("data lo", v, 16'h50);
      idle;
      $display("test narrow done");
      print_verdict;
   end
endmodule

//--- verilog/clh_instruction_unit.sv
`timescale 1ns/100ps
// Notes on behaviour
// - width bit one: eight lines, zero: four
// - narrow mode: two transfers on upper nibble
// - lines and font bits choose mode, duty
// - two lines force the small font
// - any later access except function set or status read freezes lines, font
// - glyph address set loads counter, selects glyphs
// - text address set loads counter, selects text
// - busy reads one; instructions refused meanwhile
// - status shows counter from before instruction
// - data write stores, steps, maybe shifts display
// - data read returns byte, steps, no shift
// - read without address set is stale
// - read after write is stale
// - cursor shift acts like text address set
// - narrow status read takes two cycles
// - commons: eight, eleven or sixteen
// - expansion chain: nine or four drivers
// - select and direction choose transfer kind
// - data transfers busy forty microseconds scaled
// - direction bit one increments, zero decrements
`include "clh_map.svh"
module clh_instruction_unit #(
   parameter int OSC_KHZ = `CLH_NOM_OSC_KHZ,
   parameter int ROW_CYC = `CLH_ROW_CYC
) (
   // clock and reset
   input  wire logic             clock,
   input  wire logic             rst_n,
   // host bus
   input  wire logic             register_select,
   input  wire logic             wr_stb,
   input  wire logic             rd_stb,
   input  wire clh_pkg::clh_byte_t wr_data,
   output      clh_pkg::clh_byte_t rd_data,
   // mode status
   output      logic             busy_flag_bit,
   output      logic             bus_width_select,
   output      logic             two_line_mode,
   output      logic             tall_font,
   output      logic             display_on,
   output      logic             cursor_on,
   output      logic             blink_on,
   output      logic [4:0]       common_count,
   output      logic [3:0]       max_drivers,
   output      logic [4:0]       common_index,
   // expansion drivers
   output      logic             expansion_latch,
   output      logic             expansion_shift_clock,
   output      logic             expansion_alt,
   output      logic             expansion_data
);
   import clh_pkg::*;

   localparam int EXEC_CYC = (`CLH_EXEC_NS * `CLH_NOM_OSC_KHZ)
                             / (OSC_KHZ * `CLH_CLK_NS);
   localparam int SHIFT_CYC = 2 * `CLH_GLYPH_COLS * `CLH_CHARS_1L + 2;

   if (OSC_KHZ < 1 || EXEC_CYC < 1 || EXEC_CYC > `CLH_MAX_EXEC
       || ROW_CYC < SHIFT_CYC || ROW_CYC > 65535) begin : g_chk
      $error("clh_instruction_unit: unsupported parameters");
   end

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic clh_addr_t step(input clh_addr_t a, input logic up,
                                      input logic glyph);
      clh_addr_t n;
      n = up ? a + 7'h01 : a - 7'h01;
      if (glyph) n[6] = 1'b0;
      return n;
   endfunction

   function automatic logic [4:0] commons(input logic lines,
                                          input logic font);
      logic [4:0] c;
      c = `CLH_COM_1L_SMALL;
      if (lines)     c = `CLH_COM_2L;
      else if (font) c = `CLH_COM_1L_TALL;
      return c;
   endfunction

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   clh_byte_t  display_text_memory [0:127];
   clh_byte_t  glyph_pattern_memory [0:63];
   clh_addr_t  shared_address_counter_q;
   clh_addr_t  snap_q;
   clh_addr_t  ofs_q;
   clh_byte_t  buf_q;
   clh_byte_t  hold_q;
   logic [3:0] hi_q;
   logic       wr_ph_q;
   logic       rd_ph_q;
   logic       busy_q;
   logic [11:0] cnt_q;
   logic       reload_q;
   logic       glyph_sel_q;
   logic       wide_q;
   logic       lines_q;
   logic       font_q;
   logic       fs_seen_q;
   logic       lock_q;
   logic       dir_q;
   logic       dshift_q;
   logic       disp_q;
   logic       curs_q;
   logic       blink_q;
   clh_byte_t  full;
   clh_byte_t  stat;
   clh_op_t    op;
   logic       wr_fire;
   logic       rd_fire;
   logic       rd_first;
   logic       acc;
   logic       inst;
   logic       dwr;

   // ---------------------------------------------------------------
   // transfer assembly
   // ---------------------------------------------------------------
   assign full     = wide_q ? wr_data : {hi_q, wr_data[7:4]};
   assign wr_fire  = wr_stb && !busy_q && (wide_q || wr_ph_q);
   assign rd_first = wide_q || !rd_ph_q;
   assign rd_fire  = rd_stb && register_select == `CLH_SEL_DATA
                     && rd_first && !busy_q;
   assign acc      = wr_fire || rd_fire;
   assign inst     = wr_fire && register_select == `CLH_SEL_INSTR;
   assign dwr      = wr_fire && register_select == `CLH_SEL_DATA;
   assign op       = inst ? clh_decode(full) : CLH_OP_NONE;
   assign stat     = {busy_q, busy_q ? snap_q : shared_address_counter_q};

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wr_ph_q <= 1'b0;
         hi_q    <= 4'h0;
      end else if (wr_stb && !busy_q && !wide_q) begin
         wr_ph_q <= ~wr_ph_q;
         hi_q    <= wr_data[7:4];
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rd_ph_q <= 1'b0;
         hold_q  <= 8'h00;
         rd_data <= 8'h00;
      end else if (rd_stb) begin
         if (!wide_q) rd_ph_q <= ~rd_ph_q;
         if (rd_first) begin
            hold_q <= (register_select == `CLH_SEL_DATA) ? buf_q : stat;
            if (wide_q)
               rd_data <= (register_select == `CLH_SEL_DATA) ? buf_q : stat;
            else if (register_select == `CLH_SEL_DATA)
               rd_data <= {buf_q[7:4], 4'h0};
            else
               rd_data <= {stat[7:4], 4'h0};
         end else begin
            rd_data <= {hold_q[3:0], 4'h0};
         end
      end
   end

   // ---------------------------------------------------------------
   // busy timing
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         busy_q <= 1'b0;
         cnt_q  <= 12'h000;
      end else if (acc) begin
         busy_q <= 1'b1;
         cnt_q  <= 12'(EXEC_CYC - 1);
      end else if (cnt_q != 12'h000) begin
         cnt_q <= cnt_q - 12'h001;
      end else begin
         busy_q <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // address counter and memory select
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         shared_address_counter_q <= 7'h00;
         snap_q                   <= 7'h00;
         glyph_sel_q              <= 1'b0;
      end else begin
         if (acc) snap_q <= shared_address_counter_q;
         if (dwr || rd_fire)
            shared_address_counter_q <= step(shared_address_counter_q,
                                             dir_q, glyph_sel_q);
         case (op)
            CLH_OP_CLEAR, CLH_OP_HOME: begin
               shared_address_counter_q <= 7'h00;
               glyph_sel_q              <= 1'b0;
            end
            CLH_OP_GLYPH: begin
               shared_address_counter_q <= {1'b0, full[5:0]};
               glyph_sel_q              <= 1'b1;
            end
            CLH_OP_TEXT: begin
               shared_address_counter_q <= full[6:0];
               glyph_sel_q              <= 1'b0;
            end
            CLH_OP_SHIFT: begin
               if (!full[`CLH_SH_DISP]) begin
                  shared_address_counter_q <= step(shared_address_counter_q,
                                                   full[`CLH_SH_RIGHT], 1'b0);
                  glyph_sel_q <= 1'b0;
               end
            end
            default: ;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // memories and read buffer
   // ---------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (dwr && glyph_sel_q)
         glyph_pattern_memory[shared_address_counter_q[5:0]] <= full;
      if (dwr && !glyph_sel_q)
         display_text_memory[shared_address_counter_q] <= full;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         reload_q <= 1'b0;
         buf_q    <= 8'h00;
      end else begin
         if (dwr)
            reload_q <= 1'b0;
         else if (rd_fire || op == CLH_OP_GLYPH || op == CLH_OP_TEXT
                  || op == CLH_OP_CLEAR || op == CLH_OP_HOME
                  || (op == CLH_OP_SHIFT && !full[`CLH_SH_DISP]))
            reload_q <= 1'b1;
         if (busy_q && cnt_q == 12'h000 && reload_q)
            buf_q <= glyph_sel_q
               ? glyph_pattern_memory[shared_address_counter_q[5:0]]
               : display_text_memory[shared_address_counter_q];
      end
   end

   // ---------------------------------------------------------------
   // mode registers
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wide_q    <= `CLH_RST_WIDE;
         lines_q   <= `CLH_RST_LINES;
         font_q    <= `CLH_RST_FONT;
         fs_seen_q <= 1'b0;
         lock_q    <= 1'b0;
      end else if (op == CLH_OP_FUNC) begin
         wide_q    <= full[`CLH_FS_WIDTH];
         fs_seen_q <= 1'b1;
         if (!lock_q) begin
            lines_q <= full[`CLH_FS_LINES];
            font_q  <= full[`CLH_FS_FONT];
         end
      end else if (acc && fs_seen_q) begin
         lock_q <= 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         dir_q    <= `CLH_RST_DIR;
         dshift_q <= 1'b0;
         disp_q   <= 1'b0;
         curs_q   <= 1'b0;
         blink_q  <= 1'b0;
      end else begin
         case (op)
            CLH_OP_CLEAR: dir_q <= 1'b1;
            CLH_OP_ENTRY: begin
               dir_q    <= full[`CLH_EM_DIR];
               dshift_q <= full[`CLH_EM_SHIFT];
            end
            CLH_OP_DISP: begin
               disp_q  <= full[`CLH_DC_DISP];
               curs_q  <= full[`CLH_DC_CURS];
               blink_q <= full[`CLH_DC_BLINK];
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n)
         ofs_q <= 7'h00;
      else if (op == CLH_OP_CLEAR || op == CLH_OP_HOME)
         ofs_q <= 7'h00;
      else if (op == CLH_OP_SHIFT && full[`CLH_SH_DISP])
         ofs_q <= step(ofs_q, !full[`CLH_SH_RIGHT], 1'b0);
      else if (dwr && !glyph_sel_q && dshift_q)
         ofs_q <= step(ofs_q, dir_q, 1'b0);
   end

   assign busy_flag_bit    = busy_q;
   assign bus_width_select = wide_q;
   assign two_line_mode    = lines_q;
   assign tall_font        = !lines_q && font_q;
   assign display_on       = disp_q;
   assign cursor_on        = curs_q;
   assign blink_on         = blink_q;
   assign common_count     = commons(lines_q, font_q);
   assign max_drivers      = lines_q ? `CLH_DRV_2L : `CLH_DRV_1L;

   // ---------------------------------------------------------------
   // common scan and expansion serial output
   // ---------------------------------------------------------------
   logic [15:0] row_q;
   logic [4:0]  com_q;
   logic [6:0]  chr_q;
   logic [2:0]  col_q;
   logic        sclk_q;
   logic        shon_q;
   logic        alt_q;
   logic        latch_q;
   logic        sdat_q;
   logic        row_end;
   logic        line2;
   logic [4:0]  pix_row;
   clh_addr_t   taddr;
   clh_byte_t   code;

   assign row_end = row_q == 16'(ROW_CYC - 1);
   assign line2   = lines_q && com_q >= `CLH_ROWS_LINE;
   assign pix_row = line2 ? com_q - `CLH_ROWS_LINE : com_q;
   assign taddr   = (line2 ? `CLH_LINE2_BASE : 7'h00) + ofs_q + chr_q;
   assign code    = display_text_memory[taddr];

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         row_q   <= 16'h0000;
         com_q   <= 5'h00;
         alt_q   <= 1'b0;
         latch_q <= 1'b0;
      end else begin
         latch_q <= row_end;
         row_q   <= row_end ? 16'h0000 : row_q + 16'h0001;
         if (row_end) begin
            if (com_q >= common_count - 5'h01) begin
               com_q <= 5'h00;
               alt_q <= ~alt_q;
            end else begin
               com_q <= com_q + 5'h01;
            end
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         shon_q <= 1'b0;
         sclk_q <= 1'b0;
         chr_q  <= 7'h00;
         col_q  <= 3'h0;
         sdat_q <= 1'b0;
      end else if (row_end) begin
         shon_q <= 1'b1;
         sclk_q <= 1'b0;
         chr_q  <= 7'h00;
         col_q  <= 3'h0;
      end else if (shon_q) begin
         sclk_q <= ~sclk_q;
         if (!sclk_q) begin
            sdat_q <= disp_q && code < `CLH_CODE_GLYPHS
               && glyph_pattern_memory[{code[2:0], pix_row[2:0]}]
                  [3'h4 - col_q];
         end else if (col_q == `CLH_GLYPH_COLS - 3'h1) begin
            col_q <= 3'h0;
            chr_q <= chr_q + 7'h01;
            if (chr_q == (lines_q ? `CLH_CHARS_2L : `CLH_CHARS_1L) - 7'h01)
               shon_q <= 1'b0;
         end else begin
            col_q <= col_q + 3'h1;
         end
      end
   end

   assign common_index          = com_q;
   assign expansion_latch       = latch_q;
   assign expansion_shift_clock = sclk_q;
   assign expansion_alt         = alt_q;
   assign expansion_data        = sdat_q;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   logic [12:0] blen_q;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n)     blen_q <= 13'h0000;
      else if (acc)   blen_q <= 13'h0001;
      else if (busy_q) blen_q <= blen_q + 13'h0001;
   end

   a_busy_length:
   assert property (@(posedge clock) disable iff (!rst_n)
      $fell(busy_q) |-> $past(blen_q) == 13'(EXEC_CYC))
      else $error("busy length wrong");
   a_busy_refuse:
   assert property (@(posedge clock) disable iff (!rst_n)
      busy_q && wr_stb && register_select && wide_q
      |=> $stable(shared_address_counter_q))
      else $error("write taken while busy");
   a_status_busy:
   assert property (@(posedge clock) disable iff (!rst_n)
      rd_stb && !register_select && wide_q
      |=> rd_data[`CLH_BUSY_BIT] == $past(busy_q))
      else $error("status busy bit wrong");
   a_mode_locked:
   assert property (@(posedge clock) disable iff (!rst_n)
      lock_q |=> $stable(lines_q) && $stable(font_q))
      else $error("mode changed after lock");
   a_glyph_set:
   assert property (@(posedge clock) disable iff (!rst_n)
      op == CLH_OP_GLYPH |=> glyph_sel_q
      && shared_address_counter_q == {1'b0, $past(full[5:0])})
      else $error("glyph address set wrong");
   a_text_set:
   assert property (@(posedge clock) disable iff (!rst_n)
      op == CLH_OP_TEXT |=> !glyph_sel_q
      && shared_address_counter_q == $past(full[6:0]))
      else $error("text address set wrong");
   a_step_up:
   assert property (@(posedge clock) disable iff (!rst_n)
      dwr && dir_q && !glyph_sel_q |=> shared_address_counter_q
      == $past(shared_address_counter_q) + 7'h01)
      else $error("counter did not increment");
   a_commons_two:
   assert property (@(posedge clock) disable iff (!rst_n)
      lines_q |-> common_count == 5'h10 && !tall_font
      && max_drivers == 4'h4)
      else $error("two line geometry wrong");
   a_nibble_pair:
   assert property (@(posedge clock) disable iff (!rst_n)
      !wide_q && wr_stb && !busy_q && !wr_ph_q
      |=> !busy_q && $stable(shared_address_counter_q))
      else $error("first nibble executed");
endmodule
